// [common/rtm_pkg.sv]
// Purpose: Constants for the transmit and receive mode configuration block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are register indices; byte address is four times the index
package rtm_pkg;
	localparam logic [7:0] IDX_TRANSMIT_MODE = 8'h12;
	localparam logic [7:0] IDX_RECEIVE_MODE = 8'h13;
	localparam logic [7:0] IDX_RX_CONTROL = 8'h18;
	localparam logic [7:0] IDX_RX_STATUS = 8'h19;
	localparam logic [7:0] RESET_TRANSMIT_MODE = 8'h00;
	localparam logic [7:0] RESET_RECEIVE_MODE = 8'h00;
	localparam logic [7:0] MASK_TRANSMIT_MODE = 8'hfb;
	localparam logic [7:0] MASK_RECEIVE_MODE = 8'hff;
	localparam int BIT_CRC_EN = 7;
	localparam int BIT_RATE_HI = 6;
	localparam int BIT_RATE_LO = 4;
	localparam int BIT_INVERT = 3;
	localparam int BIT_IGNORE_SHORT = 3;
	localparam int BIT_MULTI = 2;
	localparam int BIT_FRAME_HI = 1;
	localparam int BIT_FRAME_LO = 0;
	localparam logic [2:0] RATE_106 = 3'h0;
	localparam logic [2:0] RATE_212 = 3'h1;
	localparam logic [2:0] RATE_424 = 3'h2;
	localparam logic [2:0] RATE_848 = 3'h3;
	localparam logic [1:0] FRAME_A = 2'h0;
	localparam logic [1:0] FRAME_B = 2'h3;
	localparam logic [5:0] SHORT_STREAM_BITS = 6'h04;
	localparam logic [15:0] CRC_PRESET_0000 = 16'h0000;
	localparam logic [15:0] CRC_PRESET_6363 = 16'h6363;
	localparam logic [15:0] CRC_PRESET_A671 = 16'ha671;
	localparam logic [15:0] CRC_PRESET_FFFF = 16'hffff;
	localparam logic [3:0] CMD_RECEIVE = 4'h8;
	localparam logic [3:0] CMD_TRANSCEIVE = 4'hc;
	localparam logic [31:0] APB_UNMAPPED_READ = 32'h0000_0000;
	typedef enum logic [1:0] {
		RTM_RX_IDLE,
		RTM_RX_ACTIVE,
		RTM_RX_TRAILER,
		RTM_RX_DONE
	} rtm_rx_state_t;
endpackage

// [hw/rtm_rate_decode.sv]
// Purpose: Decode a bit rate code into one-hot rate selects
// Assumes: Reserved codes select no rate
// Notes: Used for both transmit and receive paths
module rtm_rate_decode (
	input wire logic [2:0] rate_code,
	output logic [3:0] rate_onehot,
	output logic rate_is_106
);
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_rate
			assign rate_onehot[g] = (rate_code == 3'(g));
		end
	endgenerate
	assign rate_is_106 = rate_onehot[0];
endmodule

// [hw/rtm_mode_config.sv]
// Purpose: Transmit and receive mode registers and the receive session control
// Assumes: Frame decoder and FIFO sit outside and talk over plain strobes
// Notes: Registers reached over APB; unmapped reads return zero
// Functional notes
// - Generated CRC appended on transmit while tx crc enable is set.
// - Transmit rate field picks 106, 212, 424 or 848 kBd.
// - Modulation invert bit inverts transmitted modulation.
// - Transmit framing 00 selects type A, 11 selects type B.
// - Received CRC checked while rx crc enable is set.
// - Receive rate field picks 106, 212, 424 or 848 kBd.
// - Ignore bit discards streams under four bits, receiver stays active.
// - Multi-frame bit clear ends reception after one frame.
// - Multi-frame bit set keeps receiver open for further frames.
// - Multi-frame reception ends only by a command other than receive or transceive, or by clearing bit.
// - In multi-frame mode an error byte copy follows each stream not discarded as short.
// - Receive framing 00 selects type A, 11 selects type B.
// - Transmit mode register at index 12h, resets to 00h.
// - Receive mode register at index 13h, resets to 00h.
// - CRC preset chosen from framing and CRC enables during RF traffic.
module rtm_mode_config (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] command_register,
	input wire logic command_write,
	input wire logic [7:0] error_register,
	input wire logic rf_active,
	input wire logic [15:0] sw_crc_preset,
	input wire logic stream_end,
	input wire logic [5:0] stream_bits,
	input wire logic fifo_ready,
	output logic tx_crc_enable,
	output logic [3:0] tx_rate_select,
	output logic tx_modulation_invert,
	output logic tx_frame_a,
	output logic tx_frame_b,
	output logic rx_crc_enable,
	output logic [3:0] rx_rate_select,
	output logic rx_frame_a,
	output logic rx_frame_b,
	output logic [15:0] crc_preset,
	output logic rx_enable,
	output logic stream_discard,
	output logic rx_complete,
	output logic fifo_push,
	output logic [7:0] fifo_data
);
	logic [7:0] transmit_mode;
	logic [7:0] receive_mode;
	logic [7:0] next_transmit_mode;
	logic [7:0] next_receive_mode;
	logic rx_start;
	logic rx_stop;
	logic rx_tx106;
	logic rx_rx106;
	logic [2:0] tx_bit_rate;
	logic [2:0] rx_bit_rate;
	logic [1:0] tx_frame_format;
	logic [1:0] rx_frame_format;
	logic rx_ignore_short_stream;
	logic rx_multi_frame;
	logic [7:0] frame_count;
	logic [7:0] next_frame_count;
	logic wr_en;
	logic rd_en;
	rtm_pkg::rtm_rx_state_t state;
	rtm_pkg::rtm_rx_state_t next_state;
	logic [7:0] next_fifo_data;
	logic [31:0] next_prdata;

	// Word index from byte address
	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		reg_index = addr[9:2];
	endfunction

	// Apply byte lane zero write with reserved mask
	function automatic logic [7:0] masked_write(input logic [7:0] old, input logic [7:0] wd,
			input logic lane, input logic [7:0] mask);
		masked_write = lane ? (wd & mask) : old;
	endfunction

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	always_comb begin
		next_transmit_mode = transmit_mode;
		next_receive_mode = receive_mode;
		if (wr_en && reg_index(paddr) == rtm_pkg::IDX_TRANSMIT_MODE) begin
			next_transmit_mode = masked_write(transmit_mode, pwdata[7:0], pstrb[0],
				rtm_pkg::MASK_TRANSMIT_MODE);
		end
		if (wr_en && reg_index(paddr) == rtm_pkg::IDX_RECEIVE_MODE) begin
			next_receive_mode = masked_write(receive_mode, pwdata[7:0], pstrb[0],
				rtm_pkg::MASK_RECEIVE_MODE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_mode <= rtm_pkg::RESET_TRANSMIT_MODE;
			receive_mode <= rtm_pkg::RESET_RECEIVE_MODE;
		end else begin
			transmit_mode <= next_transmit_mode;
			receive_mode <= next_receive_mode;
		end
	end

	// Read data registered in setup so it is stable in access
	always_comb begin
		next_prdata = prdata;
		if (rd_en) begin
			unique case (reg_index(paddr))
				rtm_pkg::IDX_TRANSMIT_MODE: next_prdata = {24'h000000, transmit_mode};
				rtm_pkg::IDX_RECEIVE_MODE: next_prdata = {24'h000000, receive_mode};
				rtm_pkg::IDX_RX_STATUS: next_prdata = {22'h000000, state, frame_count};
				default: next_prdata = rtm_pkg::APB_UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= next_prdata;
		end
	end

	assign tx_bit_rate = transmit_mode[rtm_pkg::BIT_RATE_HI:rtm_pkg::BIT_RATE_LO];
	assign rx_bit_rate = receive_mode[rtm_pkg::BIT_RATE_HI:rtm_pkg::BIT_RATE_LO];
	assign tx_frame_format = transmit_mode[rtm_pkg::BIT_FRAME_HI:rtm_pkg::BIT_FRAME_LO];
	assign rx_frame_format = receive_mode[rtm_pkg::BIT_FRAME_HI:rtm_pkg::BIT_FRAME_LO];
	assign rx_ignore_short_stream = receive_mode[rtm_pkg::BIT_IGNORE_SHORT];
	assign rx_multi_frame = receive_mode[rtm_pkg::BIT_MULTI];

	rtm_rate_decode u_tx_rate (
		.rate_code(tx_bit_rate),
		.rate_onehot(tx_rate_select),
		.rate_is_106(rx_tx106)
	);

	rtm_rate_decode u_rx_rate (
		.rate_code(rx_bit_rate),
		.rate_onehot(rx_rate_select),
		.rate_is_106(rx_rx106)
	);

	// CRC may be off only at 106 kBd; otherwise forced on
	assign tx_crc_enable = transmit_mode[rtm_pkg::BIT_CRC_EN] || !rx_tx106;
	assign rx_crc_enable = receive_mode[rtm_pkg::BIT_CRC_EN] || !rx_rx106;
	assign tx_modulation_invert = transmit_mode[rtm_pkg::BIT_INVERT];
	assign tx_frame_a = (tx_frame_format == rtm_pkg::FRAME_A);
	assign tx_frame_b = (tx_frame_format == rtm_pkg::FRAME_B);
	assign rx_frame_a = (rx_frame_format == rtm_pkg::FRAME_A);
	assign rx_frame_b = (rx_frame_format == rtm_pkg::FRAME_B);

	// Automatic preset during RF traffic
	always_comb begin
		crc_preset = sw_crc_preset;
		if (rf_active) begin
			if (tx_frame_b || rx_frame_b) begin
				crc_preset = rtm_pkg::CRC_PRESET_FFFF;
			end else if (tx_crc_enable || rx_crc_enable) begin
				crc_preset = rtm_pkg::CRC_PRESET_6363;
			end else begin
				crc_preset = rtm_pkg::CRC_PRESET_0000;
			end
		end
	end

	assign rx_start = command_write && (command_register == rtm_pkg::CMD_RECEIVE ||
		command_register == rtm_pkg::CMD_TRANSCEIVE);
	assign rx_stop = command_write && command_register != rtm_pkg::CMD_RECEIVE;
	assign stream_discard = stream_end && rx_ignore_short_stream &&
		stream_bits < rtm_pkg::SHORT_STREAM_BITS;

	// Receive session sequencing
	always_comb begin
		next_state = state;
		next_frame_count = frame_count;
		next_fifo_data = fifo_data;
		unique case (state)
			rtm_pkg::RTM_RX_IDLE, rtm_pkg::RTM_RX_DONE: begin
				if (rx_start) begin
					next_state = rtm_pkg::RTM_RX_ACTIVE;
					next_frame_count = 8'h00;
				end
			end
			rtm_pkg::RTM_RX_ACTIVE: begin
				if (rx_stop && !rx_start) begin
					next_state = rtm_pkg::RTM_RX_IDLE;
				end else if (stream_end && !stream_discard) begin
					next_frame_count = frame_count + 8'h01;
					if (rx_multi_frame) begin
						next_state = rtm_pkg::RTM_RX_TRAILER;
						next_fifo_data = error_register;
					end else begin
						next_state = rtm_pkg::RTM_RX_DONE;
					end
				end
			end
			rtm_pkg::RTM_RX_TRAILER: begin
				if (fifo_ready) begin
					// Multi-frame clear meanwhile still ends the session
					next_state = rx_multi_frame ? rtm_pkg::RTM_RX_ACTIVE :
						rtm_pkg::RTM_RX_DONE;
				end
			end
		endcase
		// Multi bit cleared after a frame ends session
		if (state == rtm_pkg::RTM_RX_ACTIVE && !rx_multi_frame && !stream_end &&
				!command_write && frame_count != 8'h00) begin
			next_state = rtm_pkg::RTM_RX_DONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= rtm_pkg::RTM_RX_IDLE;
			frame_count <= 8'h00;
			fifo_data <= 8'h00;
		end else begin
			state <= next_state;
			frame_count <= next_frame_count;
			fifo_data <= next_fifo_data;
		end
	end

	assign rx_enable = (state == rtm_pkg::RTM_RX_ACTIVE);
	assign fifo_push = (state == rtm_pkg::RTM_RX_TRAILER);
	assign rx_complete = (state == rtm_pkg::RTM_RX_DONE);

	property p_tx_reset_zero;
		@(posedge pclk) $rose(presetn) |-> transmit_mode == 8'h00;
	endproperty
	a_tx_reset_zero: assert property (p_tx_reset_zero) else $error("transmit mode not zero");

	property p_rx_reset_zero;
		@(posedge pclk) $rose(presetn) |-> receive_mode == 8'h00;
	endproperty
	a_rx_reset_zero: assert property (p_rx_reset_zero) else $error("receive mode not zero");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn) transmit_mode[2] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_tx_write;
		@(posedge pclk) disable iff (!presetn)
			wr_en && pstrb[0] && reg_index(paddr) == rtm_pkg::IDX_TRANSMIT_MODE
			|=> transmit_mode == ($past(pwdata[7:0]) & rtm_pkg::MASK_TRANSMIT_MODE);
	endproperty
	a_tx_write: assert property (p_tx_write) else $error("transmit mode write lost");

	property p_tx_crc;
		@(posedge pclk) disable iff (!presetn)
			tx_crc_enable == (transmit_mode[rtm_pkg::BIT_CRC_EN] || tx_bit_rate != rtm_pkg::RATE_106);
	endproperty
	a_tx_crc: assert property (p_tx_crc) else $error("tx crc not enabled");

	property p_rx_crc;
		@(posedge pclk) disable iff (!presetn)
			rx_crc_enable == (receive_mode[rtm_pkg::BIT_CRC_EN] || rx_bit_rate != rtm_pkg::RATE_106);
	endproperty
	a_rx_crc: assert property (p_rx_crc) else $error("rx crc not enabled");

	property p_single_done;
		@(posedge pclk) disable iff (!presetn)
			rx_enable && stream_end && !stream_discard && !rx_multi_frame && !command_write
			|=> rx_complete && !rx_enable;
	endproperty
	a_single_done: assert property (p_single_done) else $error("receiver not closed");

	property p_multi_trailer;
		@(posedge pclk) disable iff (!presetn)
			rx_enable && stream_end && !stream_discard && rx_multi_frame && !command_write
			|=> fifo_push && fifo_data == $past(error_register);
	endproperty
	a_multi_trailer: assert property (p_multi_trailer) else $error("error byte missing");

	property p_discard;
		@(posedge pclk) disable iff (!presetn)
			rx_enable && stream_discard && !command_write |=> rx_enable;
	endproperty
	a_discard: assert property (p_discard) else $error("short stream ended rx");

	property p_invert;
		@(posedge pclk) disable iff (!presetn) tx_modulation_invert == transmit_mode[3];
	endproperty
	a_invert: assert property (p_invert) else $error("invert mismatch");

	property p_cmd_stop;
		@(posedge pclk) disable iff (!presetn) rx_enable && rx_stop && !rx_start |=> !rx_enable;
	endproperty
	a_cmd_stop: assert property (p_cmd_stop) else $error("receiver not stopped");

	property p_preset_b;
		@(posedge pclk) disable iff (!presetn)
			rf_active && (tx_frame_format == rtm_pkg::FRAME_B || rx_frame_format == rtm_pkg::FRAME_B)
			|-> crc_preset == rtm_pkg::CRC_PRESET_FFFF;
	endproperty
	a_preset_b: assert property (p_preset_b) else $error("crc preset not automatic");
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the transmit and receive mode block
// Assumes: Zero-wait APB slave; receive session timing as handed over
// Notes: Byte address is four times the register index
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, command_write, rf_active, stream_end, fifo_ready;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0] pstrb, command_register, tx_rate_select, rx_rate_select;
	logic [7:0] error_register, fifo_data;
	logic [15:0] sw_crc_preset, crc_preset;
	logic [5:0] stream_bits;
	logic pready, pslverr, tx_crc_enable, tx_modulation_invert, tx_frame_a, tx_frame_b;
	logic rx_crc_enable, rx_frame_a, rx_frame_b, rx_enable, stream_discard, rx_complete;
	logic fifo_push, disc;
	int n_mismatch, samples_checked;
	localparam logic [31:0] TX = 32'h0000_0048;
	localparam logic [31:0] RX = 32'h0000_004c;
	rtm_mode_config rtm_mode_config_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .command_register(command_register),
		.command_write(command_write), .error_register(error_register), .rf_active(rf_active),
		.sw_crc_preset(sw_crc_preset), .stream_end(stream_end), .stream_bits(stream_bits),
		.fifo_ready(fifo_ready), .tx_crc_enable(tx_crc_enable), .tx_rate_select(tx_rate_select),
		.tx_modulation_invert(tx_modulation_invert), .tx_frame_a(tx_frame_a),
		.tx_frame_b(tx_frame_b), .rx_crc_enable(rx_crc_enable), .rx_rate_select(rx_rate_select),
		.rx_frame_a(rx_frame_a), .rx_frame_b(rx_frame_b), .crc_preset(crc_preset),
		.rx_enable(rx_enable), .stream_discard(stream_discard), .rx_complete(rx_complete),
		.fifo_push(fifo_push), .fifo_data(fifo_data));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task automatic rdchk(input string name, input logic [31:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(name, exp, rd);
	endtask
	task automatic cmd(input logic [3:0] c);
		@(posedge pclk);
		command_register <= c;
		command_write <= 1'b1;
		@(posedge pclk);
		command_write <= 1'b0;
		@(negedge pclk);
	endtask
	task automatic stream(input logic [5:0] b);
		@(posedge pclk);
		stream_end <= 1'b1;
		stream_bits <= b;
		@(negedge pclk);
		disc = stream_discard;
		@(posedge pclk);
		stream_end <= 1'b0;
		@(negedge pclk);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, command_write, rf_active, stream_end, fifo_ready} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		command_register = 4'h0;
		error_register = 8'ha5;
		sw_crc_preset = 16'h1234;
		stream_bits = 6'h00;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("tx reset", TX, 32'h0);
		rdchk("rx reset", RX, 32'h0);
		chk("tx rate reset", 32'h1, {28'h0, tx_rate_select});
		chk("preset idle", {16'h0, sw_crc_preset}, {16'h0, crc_preset});
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, TX, 32'h8c | (i << 4) | (i & 3));
			apb(1'b1, RX, 32'h88 | (i << 4) | (i & 3));
			rdchk("tx mode", TX, 32'h88 | (i << 4) | (i & 3));
			rdchk("rx mode", RX, 32'h88 | (i << 4) | (i & 3));
			@(negedge pclk);
			chk("tx rate", i < 4 ? 32'h1 << i : 32'h0, {28'h0, tx_rate_select});
			chk("rx rate", i < 4 ? 32'h1 << i : 32'h0, {28'h0, rx_rate_select});
			chk("tx frames", {i % 4 == 0, i % 4 == 3}, {tx_frame_a, tx_frame_b});
			chk("rx frames", {i % 4 == 0, i % 4 == 3}, {rx_frame_a, rx_frame_b});
			chk("tx crc inv", 32'h3, {tx_crc_enable, tx_modulation_invert});
			chk("rx crc", 32'h1, rx_crc_enable);
		end
		apb(1'b1, TX, 32'hffff_ffff);
		rdchk("tx wide", TX, 32'hfb);
		pstrb <= 4'he;
		apb(1'b1, TX, 32'h00);
		rdchk("lane off", TX, 32'hfb);
		pstrb <= 4'hf;
		apb(1'b1, 32'h50, 32'hff);
		chk("unmapped err", 32'h0, pslverr);
		rdchk("unmapped", 32'h50, 32'h0);
		apb(1'b1, TX, 32'h20);
		apb(1'b1, RX, 32'h00);
		@(negedge pclk);
		chk("crc forced", 32'h2, {tx_crc_enable, rx_crc_enable});
		@(posedge pclk);
		rf_active <= 1'b1;
		apb(1'b1, TX, 32'h00);
		@(negedge pclk);
		chk("crc off 106", 32'h0, {tx_crc_enable, tx_modulation_invert});
		chk("preset none", 32'h0, crc_preset);
		apb(1'b1, TX, 32'h80);
		apb(1'b1, RX, 32'h80);
		@(negedge pclk);
		chk("preset crc", 32'h6363, crc_preset);
		apb(1'b1, TX, 32'h83);
		apb(1'b1, RX, 32'h83);
		@(negedge pclk);
		chk("preset b", 32'hffff, crc_preset);
		apb(1'b1, RX, 32'h00);
		cmd(4'hc);
		chk("single open", 32'h1, rx_enable);
		stream(6'h03);
		chk("single end", 32'h2, {disc, rx_enable, rx_complete, fifo_push});
		cmd(4'h0);
		apb(1'b1, RX, 32'h94);
		cmd(4'h8);
		stream(6'h08);
		chk("trailer", 32'h1a5, {fifo_push, fifo_data});
		repeat (3) @(negedge pclk);
		chk("trailer held", 32'h2, {fifo_push, rx_complete});
		@(posedge pclk);
		fifo_ready <= 1'b1;
		@(posedge pclk);
		fifo_ready <= 1'b0;
		@(negedge pclk);
		chk("multi open", 32'h2, {rx_enable, rx_complete});
		apb(1'b1, RX, 32'h9c);
		stream(6'h03);
		chk("short drop", 32'h6, {disc, rx_enable, fifo_push});
		cmd(4'h0);
		chk("multi stop", 32'h0, {rx_enable, rx_complete});
		rdchk("frames", 32'h64, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("tx rereset", TX, 32'h0);
		rdchk("rx rereset", RX, 32'h0);
		complete_run();
	end
endmodule
